/* File: hdl/pmr_readout.sv */
`timescale 1ns/1ps
// Behaviour
// - Two signal channels, each one of three field components, chosen by variant.
// - Measurement registers are read-only snapshots of signal path stages.
// - Junction temperature is 16-bit unsigned, only 0 to 32767 used.
// - Temperature typically reads 100 at -40 C and 12000 at 160 C.
// - Each channel has a 16-bit two's-complement compensated field register.
// - Angle inputs are 16-bit signed values after customer corrections.
// - Position result is 16-bit unsigned, 0 to 32767.
// - Output code is 16-bit unsigned, 0 to 32767, equivalent of output.
// - Offsets both zero: amplitude about 1.6 times root of squared sum.
// - Either offset at 32767 selects the alternative amplitude calculation.
// - Registers are read by modulating the output pin, no extra pin.
module pmr_readout #(
  parameter int BIT_DIV = pmr_pkg::BIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Signal path sample
  input wire logic sample_valid,
  input wire pmr_pkg::pmr_sample_s sample,
  input wire logic [1:0] variant_select,
  // Configuration
  input wire pmr_pkg::pmr_offset_s cust_offset,
  // Output pin, two-way
  input wire logic out_pin_sense,
  output logic out_pin_drive,
  output logic out_pin_oe,
  // Status
  output logic alt_amplitude,
  output logic [1:0] channel_select
);

  // Below 8 a reply's own last low bit could pass for a fresh start bit
  if (BIT_DIV < 8 || BIT_DIV > 65535) begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] clamp_unsigned(input logic [15:0] v);
    clamp_unsigned = v[15] ? pmr_pkg::UNSIGNED_MAX : v;
  endfunction : clamp_unsigned

  function automatic logic [15:0] magnitude(input logic signed [15:0] v);
    logic [16:0] m;
    m = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    magnitude = m[16] ? 16'hFFFF : m[15:0];
  endfunction : magnitude

  function automatic logic [16:0] isqrt(input logic [32:0] v);
    logic [33:0] rem;
    logic [16:0] root;
    logic [18:0] trial;
    logic [33:0] vx;
    rem = '0;
    root = '0;
    trial = '0;
    // One pad bit lets the top pair be taken like all the others
    vx = {1'b0, v};
    for (int i = 16; i >= 0; i--) begin
      rem = {rem[31:0], vx[2 * i + 1 -: 2]};
      trial = {root, 2'b01};
      if (rem >= 34'(trial)) begin
        rem = rem - 34'(trial);
        root = {root[15:0], 1'b1};
      end else begin
        root = {root[15:0], 1'b0};
      end
    end
    isqrt = root;
  endfunction : isqrt

  // Scale by 1.59375: cheap shifts stand in for the nominal factor
  function automatic logic [15:0] scale_16(input logic [16:0] v);
    logic [19:0] s;
    s = 20'(v) + 20'(v >> 1) + 20'(v >> 4) + 20'(v >> 5);
    scale_16 = (s > 20'(16'hFFFF)) ? 16'hFFFF : s[15:0];
  endfunction : scale_16

  // ==========================================================================
  // Variant decides which pair of components feeds the channels
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      channel_select <= 2'h0;
    end else begin
      channel_select <= variant_select;
    end
  end

  // ==========================================================================
  // Amplitude datapath
  logic [15:0] mag_first;
  logic [15:0] mag_second;
  logic [32:0] sum_sq;
  logic [15:0] amp_root;
  logic [15:0] amp_alt;
  logic use_alt;

  always_comb begin
    mag_first = magnitude(sample.angle_first);
    mag_second = magnitude(sample.angle_second);
    sum_sq = 33'(mag_first * mag_first) + 33'(mag_second * mag_second);
    amp_root = scale_16(isqrt(sum_sq));
    // Alternative: larger magnitude plus half the smaller, then scaled
    if (mag_first > mag_second) begin
      amp_alt = scale_16(17'(mag_first) + 17'(mag_second >> 1));
    end else begin
      amp_alt = scale_16(17'(mag_second) + 17'(mag_first >> 1));
    end
    use_alt = (cust_offset.offset_first == pmr_pkg::OFFSET_ACTIVE) ||
              (cust_offset.offset_second == pmr_pkg::OFFSET_ACTIVE);
  end

  // ==========================================================================
  // Measurement registers, written only by the signal path
  logic [15:0] junction_temperature_ff;
  logic [15:0] compensated_field_first_ff;
  logic [15:0] compensated_field_second_ff;
  logic [15:0] angle_input_first_ff;
  logic [15:0] angle_input_second_ff;
  logic [15:0] position_result_ff;
  logic [15:0] output_code_ff;
  logic [15:0] field_amplitude_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      junction_temperature_ff <= pmr_pkg::REG_RESET;
      compensated_field_first_ff <= pmr_pkg::REG_RESET;
      compensated_field_second_ff <= pmr_pkg::REG_RESET;
      angle_input_first_ff <= pmr_pkg::REG_RESET;
      angle_input_second_ff <= pmr_pkg::REG_RESET;
      position_result_ff <= pmr_pkg::REG_RESET;
      output_code_ff <= pmr_pkg::REG_RESET;
      field_amplitude_ff <= pmr_pkg::REG_RESET;
    end else if (sample_valid) begin
      // Calibration lives upstream; the register carries the count as given, clamped at 32767
      junction_temperature_ff <= clamp_unsigned(sample.temperature);
      compensated_field_first_ff <= sample.comp_first;
      compensated_field_second_ff <= sample.comp_second;
      angle_input_first_ff <= sample.angle_first;
      angle_input_second_ff <= sample.angle_second;
      position_result_ff <= clamp_unsigned(sample.position);
      output_code_ff <= clamp_unsigned(sample.out_code);
      field_amplitude_ff <= use_alt ? amp_alt : amp_root;
    end
  end

  // Mode flag tells which formula produced the amplitude now held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alt_amplitude <= 1'b0;
    end else if (sample_valid) begin
      alt_amplitude <= use_alt;
    end
  end

  // ==========================================================================
  // Register readback, unused indices answer zero
  function automatic logic [15:0] read_reg(input logic [3:0] idx,
                                           input logic [127:0] regs);
    read_reg = (idx <= pmr_pkg::IDX_FIELD_AMPLITUDE) ? regs[idx[2:0] * 16 +: 16] : 16'h0000;
  endfunction : read_reg

  logic [127:0] reg_bank;
  assign reg_bank = {field_amplitude_ff, output_code_ff, position_result_ff,
                     angle_input_second_ff, angle_input_first_ff,
                     compensated_field_second_ff, compensated_field_first_ff,
                     junction_temperature_ff};

  // ==========================================================================
  // Output pin link: pin level synchronised, bit rate from a divider
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic [15:0] div_ff;
  logic bit_en;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else begin
      pin_meta_ff <= out_pin_sense;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign bit_en = (div_ff == 16'(BIT_DIV - 1));

  pmr_pkg::pmr_link_e state_ff;
  logic [3:0] addr_ff;
  logic [4:0] bit_cnt_ff;
  logic [15:0] shift_ff;

  // Divider restarts at the middle of the start bit so sampling lands mid-bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= 16'h0000;
    end else if (state_ff == pmr_pkg::LINK_IDLE && !pin_sync_ff) begin
      div_ff <= (div_ff == 16'(BIT_DIV / 2)) ? 16'h0000 : div_ff + 16'h0001;
    end else if (state_ff == pmr_pkg::LINK_IDLE) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= bit_en ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Frame decode
  // Half a bit after the start edge puts every later sample mid-bit
  localparam logic [15:0] HALF_BIT = 16'(BIT_DIV / 2);
  logic start_seen;
  logic in_addr;
  logic in_turn;
  logic in_data;
  logic last_addr_bit;
  logic last_data_bit;

  // Start bit confirmed low at its middle
  assign start_seen = (state_ff == pmr_pkg::LINK_IDLE) && !pin_sync_ff &&
                      (div_ff == HALF_BIT);
  assign in_addr = (state_ff == pmr_pkg::LINK_ADDR);
  assign in_turn = (state_ff == pmr_pkg::LINK_TURN);
  assign in_data = (state_ff == pmr_pkg::LINK_DATA);
  assign last_addr_bit = (bit_cnt_ff == 5'(pmr_pkg::ADDR_BITS - 1));
  assign last_data_bit = (bit_cnt_ff == 5'(pmr_pkg::REG_WIDTH - 1));

  // State walks idle, address, turnaround, data and back to idle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= pmr_pkg::LINK_IDLE;
    end else begin
      unique case (state_ff)
        pmr_pkg::LINK_IDLE: begin
          // Nothing but a confirmed start bit leaves idle
          if (start_seen) begin
            state_ff <= pmr_pkg::LINK_ADDR;
          end
        end
        pmr_pkg::LINK_ADDR: begin
          if (bit_en && last_addr_bit) begin
            state_ff <= pmr_pkg::LINK_TURN;
          end
        end
        pmr_pkg::LINK_TURN: begin
          if (bit_en) begin
            state_ff <= pmr_pkg::LINK_DATA;
          end
        end
        pmr_pkg::LINK_DATA: begin
          if (bit_en && last_data_bit) begin
            state_ff <= pmr_pkg::LINK_IDLE;
          end
        end
      endcase
    end
  end

  // Bit counter restarts at the start bit and again at the turnaround
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_ff <= 5'h00;
    end else if (start_seen || (in_turn && bit_en)) begin
      bit_cnt_ff <= 5'h00;
    end else if ((in_addr || in_data) && bit_en) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // Index shifts in MSB first, one mid-bit sample at a time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff <= 4'h0;
    end else if (in_addr && bit_en) begin
      addr_ff <= {addr_ff[2:0], pin_sync_ff};
    end
  end

  // Snapshot keeps the word coherent if a sample lands mid-reply
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= 16'h0000;
    end else if (in_turn && bit_en) begin
      shift_ff <= read_reg(addr_ff, reg_bank);
    end else if (in_data && bit_en) begin
      shift_ff <= {shift_ff[14:0], 1'b0};
    end
  end

  // ==========================================================================
  // Reply drive: the device drives the pin only while replying
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_pin_drive <= 1'b1;
      out_pin_oe <= 1'b0;
    end else begin
      out_pin_oe <= in_data;
      out_pin_drive <= in_data ? shift_ff[15] : 1'b1;
    end
  end

endmodule : pmr_readout

/* File: shared/pmr_pkg.sv */
package pmr_pkg;

  // ==========================================================================
  // Register indices on the output-pin link
  localparam logic [3:0] IDX_JUNCTION_TEMPERATURE = 4'h0;
  localparam logic [3:0] IDX_COMPENSATED_FIELD_FIRST = 4'h1;
  localparam logic [3:0] IDX_COMPENSATED_FIELD_SECOND = 4'h2;
  localparam logic [3:0] IDX_ANGLE_INPUT_FIRST = 4'h3;
  localparam logic [3:0] IDX_ANGLE_INPUT_SECOND = 4'h4;
  localparam logic [3:0] IDX_POSITION_RESULT = 4'h5;
  localparam logic [3:0] IDX_OUTPUT_CODE = 4'h6;
  localparam logic [3:0] IDX_FIELD_AMPLITUDE = 4'h7;

  // ==========================================================================
  // Field layout and reset values
  localparam int REG_WIDTH = 16;
  localparam int ADDR_BITS = 4;
  localparam logic [15:0] UNSIGNED_MAX = 16'h7FFF;
  localparam logic [15:0] OFFSET_ACTIVE = 16'h7FFF;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ==========================================================================
  // Typical temperature calibration points, counts
  localparam logic [15:0] TEMP_COUNT_MINUS40 = 16'h0064;
  localparam logic [15:0] TEMP_COUNT_PLUS160 = 16'h2EE0;

  // ==========================================================================
  // Link timing
  localparam int CLOCK_MHZ = 40;
  localparam int BIT_TIME_US = 10;
  localparam int BIT_CYCLES = BIT_TIME_US * CLOCK_MHZ;

  // ==========================================================================
  // Link states, Gray coded along the frame
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ADDR = 2'b01,
    LINK_TURN = 2'b11,
    LINK_DATA = 2'b10
  } pmr_link_e;

  // ==========================================================================
  // One processed sample from the signal path
  typedef struct packed {
    logic [15:0] temperature;
    logic signed [15:0] comp_first;
    logic signed [15:0] comp_second;
    logic signed [15:0] angle_first;
    logic signed [15:0] angle_second;
    logic [15:0] position;
    logic [15:0] out_code;
  } pmr_sample_s;

  // Customer offset settings from nonvolatile configuration
  typedef struct packed {
    logic [15:0] offset_first;
    logic [15:0] offset_second;
  } pmr_offset_s;

endpackage : pmr_pkg

/* File: sim/pmr_prog.sv */
`timescale 1ns/1ps
// ==========================================================
// Programmer on the sensor output pin
module pmr_prog #(
  parameter int B = 16
) (
  // Clock
  input wire logic clock,
  // Pin sense
  input wire logic pin,
  input wire logic dev_drv,
  // Pin pull-down, released means pulled up
  output logic pull_low
);
  initial pull_low = 1'b0;
  task automatic read(input logic [3:0] idx, output logic [15:0] data, output bit ok);
    logic [4:0] hdr;
    int n;
    hdr = {1'b0, idx};
    data = 'x;
    ok = 1'b0;
    n = 0;
    for (int i = 4; i >= 0; i--) begin
      @(posedge clock);
      pull_low <= !hdr[i];
      repeat (B - 1) @(posedge clock);
    end
    @(posedge clock);
    pull_low <= 1'b0;
    while (dev_drv !== 1'b1 && n < 8 * B) begin
      @(posedge clock);
      n++;
    end
    if (dev_drv === 1'b1) begin
      ok = 1'b1;
      repeat (B / 2) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
        data[i] = pin;
        repeat (B) @(posedge clock);
      end
    end
    // One idle bit keeps frames apart
    repeat (B) @(posedge clock);
  endtask : read
endmodule : pmr_prog

/* File: sim/pmr_readout_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker
module pmr_readout_chk #(
  parameter int BIT_DIV = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Sample side
  input wire logic sample_valid,
  input wire pmr_pkg::pmr_sample_s sample,
  input wire logic [1:0] variant_select,
  input wire pmr_pkg::pmr_offset_s cust_offset,
  // Pin and status
  input wire logic out_pin_sense,
  input wire logic out_pin_drive,
  input wire logic out_pin_oe,
  input wire logic alt_amplitude,
  input wire logic [1:0] channel_select
);
  logic [15:0] hi_cnt_ff;
  logic [15:0] since_low_ff;
  logic act;
  assign act = (cust_offset.offset_first == pmr_pkg::OFFSET_ACTIVE)
    || (cust_offset.offset_second == pmr_pkg::OFFSET_ACTIVE);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_ff <= 16'h0000;
    end else begin
      hi_cnt_ff <= out_pin_oe ? hi_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  // Saturates, so a long idle spell cannot wrap into a recent low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since_low_ff <= 16'hFFFF;
    end else if (!out_pin_sense) begin
      since_low_ff <= 16'h0000;
    end else if (since_low_ff != 16'hFFFF) begin
      since_low_ff <= since_low_ff + 16'h0001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_chan_follow: assert property (
    $past(reset_n) |-> channel_select == $past(variant_select)) else $error("variant lag wrong");
  chk_alt_select: assert property (
    sample_valid |=> alt_amplitude == $past(act)) else $error("amplitude mode wrong");
  chk_alt_hold: assert property (
    $changed(alt_amplitude) |-> $past(sample_valid)) else $error("mode changed without sample");
  chk_idle_high: assert property (
    !out_pin_oe |-> out_pin_drive) else $error("pin value low while idle");
  chk_reply_len: assert property (
    $fell(out_pin_oe) |-> hi_cnt_ff == 16 * BIT_DIV) else $error("reply length wrong");
  chk_bit_hold: assert property (
    out_pin_oe && $past(out_pin_oe) && (hi_cnt_ff % BIT_DIV != 0) |-> $stable(out_pin_drive))
    else $error("reply bit changed mid bit");
  chk_idle_gap: assert property (
    $fell(out_pin_oe) |-> !out_pin_oe [*8]) else $error("drive resumed too soon");
  chk_reply_cause: assert property (
    $rose(out_pin_oe) |-> since_low_ff < 7 * BIT_DIV + 8) else $error("reply without request");
  cover property (sample_valid && act);
  cover property (sample_valid && !act);
  cover property ($fell(out_pin_oe));
endmodule : pmr_readout_chk

bind pmr_readout pmr_readout_chk #(.BIT_DIV(BIT_DIV)) u_chk (
  .clock(clock), .reset_n(reset_n), .sample_valid(sample_valid), .sample(sample),
  .variant_select(variant_select), .cust_offset(cust_offset), .out_pin_sense(out_pin_sense),
  .out_pin_drive(out_pin_drive), .out_pin_oe(out_pin_oe), .alt_amplitude(alt_amplitude),
  .channel_select(channel_select));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// Testbench
module tb_top;
  localparam int B = 16;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic sample_valid = 1'b0;
  pmr_pkg::pmr_sample_s sample = '0;
  logic [1:0] variant_select = 2'h0;
  pmr_pkg::pmr_offset_s cust_offset = '0;
  logic out_pin_drive;
  logic out_pin_oe;
  logic alt_amplitude;
  logic [1:0] channel_select;
  logic pull_low;
  logic pin;
  int n_mismatch = 0;
  int samples_checked = 0;
  assign pin = out_pin_oe ? out_pin_drive : !pull_low;
  pmr_readout #(.BIT_DIV(B)) dut (.clock(clock), .reset_n(reset_n),
    .sample_valid(sample_valid), .sample(sample), .variant_select(variant_select),
    .cust_offset(cust_offset), .out_pin_sense(pin), .out_pin_drive(out_pin_drive),
    .out_pin_oe(out_pin_oe), .alt_amplitude(alt_amplitude), .channel_select(channel_select));
  pmr_prog #(.B(B)) prog (.clock(clock), .pin(pin), .dev_drv(out_pin_oe), .pull_low(pull_low));
  initial forever #12.5 clock = ~clock;
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd(input logic [3:0] idx, input logic [15:0] exp, input int tol);
    logic [15:0] d;
    bit ok;
    prog.read(idx, d, ok);
    samples_checked++;
    if (!ok || $isunknown(d) || d > exp + tol || d + tol < exp) begin
      n_mismatch++;
      $display("mismatch register %0d expected %h seen %h", idx, exp, d);
    end
  endtask : rd
  task automatic push(input pmr_pkg::pmr_sample_s s);
    @(posedge clock);
    sample <= s;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask : push
  task automatic t_reset;
    repeat (3) @(posedge clock);
    check("pin value", 16'h0001, {15'h0, out_pin_drive});
    check("pin enable", 16'h0000, {15'h0, out_pin_oe});
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 8; i++) rd(4'(i), pmr_pkg::REG_RESET, 0);
  endtask : t_reset
  task automatic t_values;
    pmr_pkg::pmr_sample_s s;
    s = {pmr_pkg::TEMP_COUNT_PLUS160, 64'hFFFE_8000_7FFF_8001, pmr_pkg::UNSIGNED_MAX, 16'h1234};
    push(s);
    for (int i = 0; i < 7; i++) rd(4'(i), s[111 - 16 * i -: 16], 0);
    rd(4'h8, pmr_pkg::REG_RESET, 0);
    rd(4'hF, pmr_pkg::REG_RESET, 0);
  endtask : t_values
  task automatic t_burst;
    @(posedge clock);
    sample <= '1;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample <= {16'h8000, 64'h0, 16'hFFFF, 16'h8001};
    @(posedge clock);
    sample_valid <= 1'b0;
    rd(pmr_pkg::IDX_JUNCTION_TEMPERATURE, pmr_pkg::UNSIGNED_MAX, 0);
    rd(pmr_pkg::IDX_COMPENSATED_FIELD_FIRST, 16'h0000, 0);
    rd(pmr_pkg::IDX_POSITION_RESULT, pmr_pkg::UNSIGNED_MAX, 0);
    rd(pmr_pkg::IDX_OUTPUT_CODE, pmr_pkg::UNSIGNED_MAX, 0);
  endtask : t_burst
  task automatic t_amp;
    logic [31:0] offs [4] = '{32'h0, 32'h7FFF_0000, 32'h0000_7FFF, 32'h7FFE_0000};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      cust_offset <= offs[i];
      push({48'h0, 16'h012C, 16'h0190, 32'h0});
      // The flag updates on the capture edge, so look once it has settled
      @(negedge clock);
      check("alt mode", {15'h0, i == 1 || i == 2}, {15'h0, alt_amplitude});
      rd(pmr_pkg::IDX_FIELD_AMPLITUDE, (i == 1 || i == 2) ? 16'h036C : 16'h031D, 3);
    end
  endtask : t_amp
  task automatic t_variant;
    for (int v = 0; v < 4; v++) begin
      @(posedge clock);
      variant_select <= 2'(v);
      repeat (2) @(posedge clock);
      check("channel select", 16'(v), {14'h0, channel_select});
    end
  endtask : t_variant
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    t_reset();
    t_values();
    t_burst();
    t_amp();
    t_variant();
    wrap_up();
  end
  // About four times the expected run
  initial begin
    #1ms;
    n_mismatch++;
    $display("mismatch run end expected done seen timeout");
    wrap_up();
  end
endmodule : tb_top
